// File: design/btr_pkg.sv
// Purpose: shared constants for the bytewide timekeeping RAM
// Assumes: one 20 MHz system clock, synchronous pin sampling
// Notes: clock registers sit at the eight top byte addresses
package btr_pkg;
  // memory geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam logic [16:0] CLK_BASE = 17'h1fff8; // first clock register
  // clock register offsets
  localparam logic [16:0] CLOCK_CONTROL_OFS = 17'h1fff8;
  localparam logic [16:0] SECONDS_AND_HALT_OFS = 17'h1fff9;
  localparam logic [16:0] MINUTES_COUNT_OFS = 17'h1fffa;
  localparam logic [16:0] HOUR_OF_DAY_OFS = 17'h1fffb;
  localparam logic [16:0] WEEKDAY_AND_TEST_OFS = 17'h1fffc;
  localparam logic [16:0] DAY_OF_MONTH_OFS = 17'h1fffd;
  localparam logic [16:0] CALENDAR_MONTH_OFS = 17'h1fffe;
  localparam logic [16:0] CALENDAR_YEAR_OFS = 17'h1ffff;
  // register index within the clock block (address low bits)
  localparam logic [2:0] IDX_CTRL = 3'h0;
  localparam logic [2:0] IDX_SEC = 3'h1;
  localparam logic [2:0] IDX_MIN = 3'h2;
  localparam logic [2:0] IDX_HOUR = 3'h3;
  localparam logic [2:0] IDX_WDAY = 3'h4;
  localparam logic [2:0] IDX_DATE = 3'h5;
  localparam logic [2:0] IDX_MON = 3'h6;
  localparam logic [2:0] IDX_YEAR = 3'h7;
  // field positions
  localparam int SET_LATCH_BIT = 7;
  localparam int SNAPSHOT_HOLD_BIT = 6;
  localparam int TIMEBASE_HALT_BIT = 7;
  localparam int FREQ_TEST_BIT = 6;
  // value field masks per register
  localparam logic [7:0] SEC_MASK = 8'h7f;
  localparam logic [7:0] MIN_MASK = 8'h7f;
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] WDAY_MASK = 8'h07;
  localparam logic [7:0] DATE_MASK = 8'h3f;
  localparam logic [7:0] MON_MASK = 8'h1f;
  localparam logic [7:0] YEAR_MASK = 8'hff;
  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  // reset values of the time counters
  localparam logic [7:0] RESET_DAY = 8'h01;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SUB_HZ = 1024; // twice the test frequency
  localparam int TEST_HZ = 512;
  localparam int SUB_DIV = CLK_HZ / SUB_HZ; // system cycles per sub tick
  localparam int SUB_PER_SEC = SUB_HZ;
  localparam int SUB_CNT_W = 10;
  localparam int DIV_CNT_W = 16;
endpackage

// File: design/btr_bcd_step.sv
// Purpose: one packed bcd counter stage with wrap to a minimum
// Assumes: value lies within min..max in bcd
// Notes: purely combinational, chained by the carry
module btr_bcd_step (
  // current value and limits
  input wire logic [7:0] value_in,
  input wire logic [7:0] min_in,
  input wire logic [7:0] max_in,
  // carry from the lower stage
  input wire logic step_in,
  // next value and carry to the upper stage
  output logic [7:0] next_out,
  output logic wrap_out
);
  // increment with bcd digit carry, wrap past the maximum
  always_comb begin
    next_out = value_in;
    wrap_out = 1'b0;
    if (step_in) begin
      if (value_in >= max_in) begin // at or beyond the limit: wrap
        next_out = min_in;
        wrap_out = 1'b1;
      end else if (value_in[3:0] >= 4'h9) begin // low digit carries
        next_out = {value_in[7:4] + 4'h1, 4'h0};
      end else begin
        next_out = {value_in[7:4], value_in[3:0] + 4'h1};
      end
    end
  end
endmodule

// File: design/btr_timekeeping_ram.sv
// Purpose: byte-wide static RAM with a bcd calendar clock at its top
// Assumes: strobes sampled synchronously on clk_sys_in
// Notes: visible clock registers are a frozen or live copy of the counters
module btr_timekeeping_ram
  import btr_pkg::*;
#(
  parameter int TICK_DIV = SUB_DIV // system cycles per 1/1024 s
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // sram strobes and address
  input wire logic [ADDR_W-1:0] addr_bus_in,
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_strobe_n_in,
  // data bus, split three ways
  input wire logic [DATA_W-1:0] data_lines_in,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  // supply monitor and open-drain power fail flag
  input wire logic supply_below_threshold_in,
  output logic power_fail_flag_n_out,
  output logic power_fail_flag_n_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  logic [DATA_W-1:0] ram_mem [0:(1<<ADDR_W)-1]; // backing store
  logic sel_active; // chip select after power fail gating
  logic wr_active; // write mode this cycle
  logic rd_drive; // outputs should be driven
  logic clk_area; // address hits the clock registers
  logic [2:0] reg_idx; // clock register index

  // the power fail gate wins over the host select
  assign sel_active = !chip_enable_n_in && !supply_below_threshold_in;
  // write mode spans the overlap of both strobes, so it opens on the later fall
  assign wr_active = sel_active && !write_strobe_n_in;
  // outputs only while reading with output enable; a write strobe kills them
  assign rd_drive = sel_active && !output_enable_n_in && write_strobe_n_in;
  assign clk_area = (addr_bus_in >= CLK_BASE);
  assign reg_idx = addr_bus_in[2:0];

  ////////////////////////////////////////////////////////////////////////////
  // control bits

  logic set_latch; // host is loading a new time
  logic snapshot_hold; // host is reading a steady snapshot
  logic timebase_halt; // oscillator stopped
  logic freq_test; // seconds lsb shows the test wave
  logic set_latch_prev; // for the falling edge of set_latch
  logic view_frozen; // visible registers not following the counters

  assign view_frozen = set_latch || snapshot_hold;

  // flag bits written by the host; unused bits are dropped on write
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      set_latch <= 1'b0;
      snapshot_hold <= 1'b0;
      freq_test <= 1'b0;
      timebase_halt <= 1'b0;
    end else if (wr_active && clk_area) begin
      case (reg_idx)
        IDX_CTRL: begin
          set_latch <= data_lines_in[SET_LATCH_BIT];
          snapshot_hold <= data_lines_in[SNAPSHOT_HOLD_BIT];
        end
        IDX_SEC: timebase_halt <= data_lines_in[TIMEBASE_HALT_BIT];
        IDX_WDAY: freq_test <= data_lines_in[FREQ_TEST_BIT];
        default: ;
      endcase
    end
  end

  // remembers set_latch so its release can be seen
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      set_latch_prev <= 1'b0;
    end else begin
      set_latch_prev <= set_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase: 1024 Hz sub ticks, seconds and test wave

  logic [DIV_CNT_W-1:0] div_cnt; // system cycles within a sub tick
  logic [SUB_CNT_W-1:0] sub_cnt; // sub ticks within a second
  logic sub_tick; // one-cycle pulse at 1024 Hz
  logic sec_tick; // one-cycle pulse once a second
  logic test_wave; // 512 Hz square wave

  assign sub_tick = !timebase_halt && (div_cnt == DIV_CNT_W'(TICK_DIV - 1));
  assign sec_tick = sub_tick && (sub_cnt == SUB_CNT_W'(SUB_PER_SEC - 1));

  // divider freezes while halted, so a restart does not give a short tick
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      div_cnt <= '0;
    end else if (timebase_halt) begin
      div_cnt <= div_cnt;
    end else if (sub_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_CNT_W'(1);
    end
  end

  // sub tick counter and the test wave share the sub tick
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sub_cnt <= '0;
      test_wave <= 1'b0;
    end else if (sub_tick) begin
      sub_cnt <= sub_cnt + SUB_CNT_W'(1);
      test_wave <= !test_wave;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // running calendar counters

  logic [7:0] cnt_sec, cnt_min, cnt_hour, cnt_wday, cnt_date, cnt_mon, cnt_year;
  logic [7:0] next_sec, next_min, next_hour, next_wday, next_date, next_mon;
  logic [7:0] next_year;
  logic c_sec, c_min, c_hour, c_date, c_mon;
  logic [7:0] month_days; // last date of the current month
  logic leap_year; // year divisible by four

  // leap test on the bcd year: tens even with ones 0/4/8, tens odd with 2/6
  always_comb begin
    if (cnt_year[4]) begin
      leap_year = (cnt_year[3:0] == 4'h2) || (cnt_year[3:0] == 4'h6);
    end else begin
      leap_year = (cnt_year[3:0] == 4'h0) || (cnt_year[3:0] == 4'h4)
                  || (cnt_year[3:0] == 4'h8);
    end
  end

  // month length table
  always_comb begin
    case (cnt_mon)
      MON_FEB: month_days = leap_year ? DAYS_29 : DAYS_28;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: month_days = DAYS_30;
      default: month_days = DAYS_31;
    endcase
  end

  // bcd stages chained by carry, 24-hour roll at 23
  btr_bcd_step u_sec (.value_in(cnt_sec), .min_in(BCD_ZERO), .max_in(SEC_MAX),
    .step_in(sec_tick), .next_out(next_sec), .wrap_out(c_sec));
  btr_bcd_step u_min (.value_in(cnt_min), .min_in(BCD_ZERO), .max_in(SEC_MAX),
    .step_in(c_sec), .next_out(next_min), .wrap_out(c_min));
  btr_bcd_step u_hour (.value_in(cnt_hour), .min_in(BCD_ZERO), .max_in(HOUR_MAX),
    .step_in(c_min), .next_out(next_hour), .wrap_out(c_hour));
  btr_bcd_step u_wday (.value_in(cnt_wday), .min_in(BCD_ONE), .max_in(WDAY_MAX),
    .step_in(c_hour), .next_out(next_wday), .wrap_out());
  btr_bcd_step u_date (.value_in(cnt_date), .min_in(BCD_ONE), .max_in(month_days),
    .step_in(c_hour), .next_out(next_date), .wrap_out(c_date));
  btr_bcd_step u_mon (.value_in(cnt_mon), .min_in(BCD_ONE), .max_in(MON_MAX),
    .step_in(c_date), .next_out(next_mon), .wrap_out(c_mon));
  btr_bcd_step u_year (.value_in(cnt_year), .min_in(BCD_ZERO), .max_in(YEAR_MAX),
    .step_in(c_mon), .next_out(next_year), .wrap_out());

  logic [7:0] vis_sec, vis_min, vis_hour, vis_wday, vis_date, vis_mon, vis_year;
  logic set_release; // set_latch just went back to zero

  assign set_release = set_latch_prev && !set_latch;

  // counters run from the timebase only; supply state never touches them
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cnt_sec <= BCD_ZERO;
      cnt_min <= BCD_ZERO;
      cnt_hour <= BCD_ZERO;
      cnt_wday <= RESET_DAY;
      cnt_date <= RESET_DAY;
      cnt_mon <= RESET_DAY;
      cnt_year <= BCD_ZERO;
    end else if (set_release) begin
      cnt_sec <= vis_sec;
      cnt_min <= vis_min;
      cnt_hour <= vis_hour;
      cnt_wday <= vis_wday;
      cnt_date <= vis_date;
      cnt_mon <= vis_mon;
      cnt_year <= vis_year;
    end else begin
      cnt_sec <= next_sec;
      cnt_min <= next_min;
      cnt_hour <= next_hour;
      cnt_wday <= next_wday;
      cnt_date <= next_date;
      cnt_mon <= next_mon;
      cnt_year <= next_year;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // visible clock registers

  // live copy each cycle; frozen copy only takes host writes
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      vis_sec <= BCD_ZERO;
      vis_min <= BCD_ZERO;
      vis_hour <= BCD_ZERO;
      vis_wday <= RESET_DAY;
      vis_date <= RESET_DAY;
      vis_mon <= RESET_DAY;
      vis_year <= BCD_ZERO;
    end else if (!view_frozen) begin
      vis_sec <= cnt_sec;
      vis_min <= cnt_min;
      vis_hour <= cnt_hour;
      vis_wday <= cnt_wday;
      vis_date <= cnt_date;
      vis_mon <= cnt_mon;
      vis_year <= cnt_year;
    end else if (wr_active && clk_area) begin
      case (reg_idx)
        IDX_SEC: vis_sec <= data_lines_in & SEC_MASK;
        IDX_MIN: vis_min <= data_lines_in & MIN_MASK;
        IDX_HOUR: vis_hour <= data_lines_in & HOUR_MASK;
        IDX_WDAY: vis_wday <= data_lines_in & WDAY_MASK;
        IDX_DATE: vis_date <= data_lines_in & DATE_MASK;
        IDX_MON: vis_mon <= data_lines_in & MON_MASK;
        IDX_YEAR: vis_year <= data_lines_in & YEAR_MASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ram write and read path

  logic [DATA_W-1:0] clk_rd; // clock register read value

  // repeated writes during a long strobe just restore the same byte
  always_ff @(posedge clk_sys_in) begin
    if (wr_active && !clk_area) begin
      ram_mem[addr_bus_in] <= data_lines_in;
    end
  end

  // flag bits read back alongside the visible values
  always_comb begin
    case (reg_idx)
      IDX_CTRL: clk_rd = {set_latch, snapshot_hold, 6'h00};
      IDX_SEC: clk_rd = {timebase_halt, vis_sec[6:1],
                         (freq_test && !timebase_halt) ? test_wave : vis_sec[0]};
      IDX_MIN: clk_rd = vis_min;
      IDX_HOUR: clk_rd = vis_hour;
      IDX_WDAY: clk_rd = {1'b0, freq_test, 1'b0, vis_wday[4:0]};
      IDX_DATE: clk_rd = vis_date;
      IDX_MON: clk_rd = vis_mon;
      default: clk_rd = vis_year;
    endcase
  end

  // ripple-through read: data follows the address every cycle in read mode
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      data_lines_out <= 8'h00;
    end else if (sel_active && write_strobe_n_in) begin
      data_lines_out <= clk_area ? clk_rd : ram_mem[addr_bus_in];
    end
  end

  // output enable registered, dropped the cycle after a strobe goes inactive
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      data_lines_oe_out <= 1'b0;
    end else begin
      data_lines_oe_out <= rd_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power fail flag

  // open drain: the pin is pulled low only while the supply is low
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      power_fail_flag_n_out <= 1'b0;
      power_fail_flag_n_oe_out <= 1'b0;
    end else begin
      power_fail_flag_n_out <= 1'b0;
      power_fail_flag_n_oe_out <= supply_below_threshold_in;
    end
  end

endmodule

// File: dv/btr_host_model.sv
// Purpose: host model driving the sram strobes of the timekeeping ram
// Assumes: strobes change on the falling clock edge only
// Notes: write data reaches the bus only while the write strobe is low
module btr_host_model
  import btr_pkg::*;
(
  // clock and resolved data wire
  input wire logic clk_in,
  input wire logic [DATA_W-1:0] dq_in,
  // strobes, address and write data
  output logic [ADDR_W-1:0] addr_out,
  output logic ce_n_out,
  output logic oe_n_out,
  output logic we_n_out,
  output logic [DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus: nothing selected
  initial begin
    addr_out = '0;
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
    we_n_out = 1'b1;
    dq_out = 8'h5a;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one write; slow stretches the strobe, address held throughout
  task automatic wr(input logic [16:0] a, input logic [7:0] d, input int slow);
    @(negedge clk_in);
    addr_out = a;
    dq_out = d;
    ce_n_out = 1'b0;
    we_n_out = 1'b0;
    repeat (1 + slow) @(negedge clk_in);
    ce_n_out = 1'b1;
    we_n_out = 1'b1;
    dq_out = ~d; // released bus must not look like the last byte
  endtask
  // one read; data taken just before the strobes go away
  task automatic rd(input logic [16:0] a, input int slow, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    repeat (2 + slow) @(negedge clk_in);
    d = dq_in;
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
  endtask
  // sustained read counting changes of data line zero
  task automatic watch(input logic [16:0] a, input int n, output int flips);
    logic last;
    flips = 0;
    @(negedge clk_in);
    addr_out = a;
    ce_n_out = 1'b0;
    oe_n_out = 1'b0;
    repeat (2) @(negedge clk_in);
    last = dq_in[0];
    repeat (n) begin
      @(negedge clk_in);
      if (dq_in[0] !== last) begin
        flips++;
      end
      last = dq_in[0];
    end
    ce_n_out = 1'b1;
    oe_n_out = 1'b1;
  endtask
endmodule

// File: dv/btr_tkram_assertions.sv
// Purpose: port-level checks of the timekeeping ram bus and power fail
// Assumes: one clock domain, one cycle answer latency
// Notes: readback check keys on the last accepted write of any address and only fires when that write hit a ram byte
module btr_tkram_assertions
  import btr_pkg::*;
#(
  parameter int TICK_DIV = SUB_DIV // same divider as the design
) (
  // watched ports
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] addr_bus_in,
  input wire logic chip_enable_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_strobe_n_in,
  input wire logic [DATA_W-1:0] data_lines_in,
  input wire logic [DATA_W-1:0] data_lines_out,
  input wire logic data_lines_oe_out,
  input wire logic supply_below_threshold_in,
  input wire logic power_fail_flag_n_out,
  input wire logic power_fail_flag_n_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  logic sel; // select as the device sees it
  logic rd_en; // a read that may drive the bus
  logic wr_en; // an accepted write
  logic [16:0] w_addr; // last written byte address
  logic [7:0] w_data; // last written byte
  assign sel = !chip_enable_n_in && !supply_below_threshold_in;
  assign rd_en = sel && !output_enable_n_in && write_strobe_n_in;
  assign wr_en = sel && !write_strobe_n_in;
  // remember the last write for the readback check
  always_ff @(posedge clk_sys_in) begin
    if (wr_en) begin
      w_addr <= addr_bus_in;
      w_data <= data_lines_in;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  oe_only_selected_a: assert property (data_lines_oe_out |-> $past(rd_en))
    else $error("data driven without select and output enable");
  read_drives_a: assert property (rd_en |=> data_lines_oe_out)
    else $error("read did not drive the data lines");
  write_quiets_a: assert property (wr_en |=> !data_lines_oe_out)
    else $error("data still driven during a write");
  pf_flag_on_a: assert property (supply_below_threshold_in |=> power_fail_flag_n_oe_out)
    else $error("power fail flag not pulled low");
  pf_flag_off_a: assert property (!supply_below_threshold_in |=> !power_fail_flag_n_oe_out)
    else $error("power fail flag held after supply returned");
  pf_low_value_a: assert property (power_fail_flag_n_out == 1'b0)
    else $error("open drain flag value not low");
  pf_blocks_a: assert property (supply_below_threshold_in [*2] |=>
      !data_lines_oe_out && $stable(data_lines_out))
    else $error("access accepted during power fail");
  ram_readback_a: assert property ((rd_en && addr_bus_in == w_addr && addr_bus_in < CLK_BASE)
      ##1 (rd_en && $stable(addr_bus_in)) |=> data_lines_out == w_data)
    else $error("ram byte read back differs from last write");
  // main scenarios
  cover property (wr_en ##1 !wr_en);
  cover property (rd_en ##1 data_lines_oe_out);
  cover property ($rose(supply_below_threshold_in));
endmodule

bind btr_timekeeping_ram btr_tkram_assertions #(.TICK_DIV(TICK_DIV)) chk_i (
  .clk_sys_in(clk_sys_in),
  .rst_in(rst_in),
  .addr_bus_in(addr_bus_in),
  .chip_enable_n_in(chip_enable_n_in),
  .output_enable_n_in(output_enable_n_in),
  .write_strobe_n_in(write_strobe_n_in),
  .data_lines_in(data_lines_in),
  .data_lines_out(data_lines_out),
  .data_lines_oe_out(data_lines_oe_out),
  .supply_below_threshold_in(supply_below_threshold_in),
  .power_fail_flag_n_out(power_fail_flag_n_out),
  .power_fail_flag_n_oe_out(power_fail_flag_n_oe_out)
);

// File: dv/test_bytewide_timekeeping_ram.sv
// Purpose: self-checking bench for the timekeeping ram
// Assumes: short divider, one second is 4096 cycles
// Notes: random ram traffic plus calendar, hold, halt and power fail cases
module test_bytewide_timekeeping_ram
  import btr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TDIV = 4; // shortened divider
  localparam int SEC_CYC = TDIV * SUB_HZ; // cycles per second
  localparam int LIMIT = 40000; // run ceiling in cycles
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic supply = 1'b0; // supply below threshold
  logic [16:0] addr;
  logic ce_n, oe_n, we_n, oe, pf, pf_oe;
  logic [7:0] host_dq, dq_out, dq_wire;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  // time loaded and time expected one second later (leap year)
  logic [7:0] tset [8] = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h24};
  logic [7:0] texp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h24};
  // the host drives only while its write strobe is low; an undriven bus shows the
  // inverse of the device's last byte, so a read that is never driven cannot pass
  assign dq_wire = oe ? dq_out : (!we_n ? host_dq : ~dq_out);
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  btr_timekeeping_ram #(.TICK_DIV(TDIV)) uut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_bus_in(addr),
    .chip_enable_n_in(ce_n), .output_enable_n_in(oe_n), .write_strobe_n_in(we_n),
    .data_lines_in(dq_wire), .data_lines_out(dq_out), .data_lines_oe_out(oe),
    .supply_below_threshold_in(supply), .power_fail_flag_n_out(pf),
    .power_fail_flag_n_oe_out(pf_oe));
  btr_host_model host (.clk_in(clk_sys_in), .dq_in(dq_wire), .addr_out(addr),
    .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n), .dq_out(host_dq));
  ////////////////////////////////////////////////////////////////////////////
  // one bcd second step, no wrap needed here
  function automatic logic [7:0] bcd_add1(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, s0;
    logic [16:0] a [12];
    logic [7:0] d [12];
    int n;
    void'($urandom(32'hd8cd27c3));
    repeat (12) @(negedge clk_sys_in);
    rst_in = 1'b0;
    host.rd(CLOCK_CONTROL_OFS, 0, v);
    chk(v, 8'h00);
    host.rd(WEEKDAY_AND_TEST_OFS, 0, v);
    chk(v, RESET_DAY);
    // random ram bytes, top ram byte and address zero as corners
    for (int i = 0; i < 12; i++) begin
      // distinct high bits per index keep the random addresses from colliding
      a[i] = (i == 0) ? CLK_BASE - 17'h1 : (i == 1) ? 17'h0 : {4'(i), 13'($urandom)};
      d[i] = 8'($urandom);
      host.wr(a[i], d[i], $urandom_range(0, 2));
    end
    for (int i = 0; i < 12; i++) begin
      host.rd(a[i], $urandom_range(0, 2), v);
      chk(v, d[i]);
    end
    // load time, then wait for the rollover into a leap day
    host.wr(CLOCK_CONTROL_OFS, 8'h80, 0);
    for (int i = 1; i < 8; i++) host.wr(CLK_BASE + 17'(i), tset[i], 0);
    host.wr(CLOCK_CONTROL_OFS, 8'h00, 0);
    v = 8'h59;
    n = 0;
    while (v == 8'h59 && n < 2000) begin
      host.rd(SECONDS_AND_HALT_OFS, 0, v);
      n++;
    end
    for (int i = 1; i < 8; i++) begin
      host.rd(CLK_BASE + 17'(i), 0, v);
      chk(v, texp[i]);
    end
    // freeze right after a tick, exactly one tick passes meanwhile
    host.wr(CLOCK_CONTROL_OFS, 8'h40, 0);
    host.rd(SECONDS_AND_HALT_OFS, 0, s0);
    repeat (SEC_CYC + SEC_CYC / 2) @(negedge clk_sys_in);
    host.rd(SECONDS_AND_HALT_OFS, 0, v);
    chk(v, s0);
    host.wr(CLOCK_CONTROL_OFS, 8'h00, 0);
    host.rd(SECONDS_AND_HALT_OFS, 0, v);
    chk(v, bcd_add1(s0));
    // halted timebase with the test bit set: nothing moves
    host.wr(CLOCK_CONTROL_OFS, 8'h80, 0);
    host.wr(SECONDS_AND_HALT_OFS, 8'hb0, 0);
    host.wr(WEEKDAY_AND_TEST_OFS, 8'h41, 0);
    host.wr(CLOCK_CONTROL_OFS, 8'h00, 0);
    repeat (SEC_CYC + 200) @(negedge clk_sys_in);
    host.rd(SECONDS_AND_HALT_OFS, 0, v);
    chk(v, 8'hb0);
    host.watch(SECONDS_AND_HALT_OFS, 64, n);
    chk(8'(n), 8'h00);
    // running timebase: 512 Hz square wave on line zero
    host.wr(CLOCK_CONTROL_OFS, 8'h80, 0);
    host.wr(SECONDS_AND_HALT_OFS, 8'h30, 0);
    host.wr(CLOCK_CONTROL_OFS, 8'h00, 0);
    host.watch(SECONDS_AND_HALT_OFS, 16 * TDIV, n);
    chk(8'(n >= 15 && n <= 17), 8'h01);
    // power fail blocks a write and pulls the flag
    supply = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk({7'h0, pf_oe}, 8'h01);
    chk({7'h0, pf}, 8'h00);
    host.wr(a[1], ~d[1], 0);
    supply = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    chk({7'h0, pf_oe}, 8'h00);
    host.rd(a[1], 0, v);
    chk(v, d[1]);
    test_done();
  end
endmodule
